//--- pbsp_consts.svh
`ifndef PBSP_CONSTS_SVH
`define PBSP_CONSTS_SVH
// --------------------------------------------------------------------------
// port geometry and pipeline figures
// --------------------------------------------------------------------------
`define PBSP_ADDR_W 8
`define PBSP_LANES 4
`define PBSP_LANE_W 8
`define PBSP_BURST_LEN 4
// cycles from command edge to data phase edge
`define PBSP_DATA_LAG 2
// strap level that selects interleaved order
`define PBSP_ORDER_INTERLEAVED 1'b1
`endif

//--- pbsp_pkg.sv
package pbsp_pkg;
  // operation latched at a load edge
  typedef enum logic [1:0] {
    PBSP_OP_IDLE,
    PBSP_OP_READ,
    PBSP_OP_WRITE
  } pbsp_op_t;
  // controller sequencer states
  typedef enum logic [1:0] {
    PBSP_ST_IDLE,
    PBSP_ST_BURST
  } pbsp_state_t;
endpackage

//--- pbsp_if.sv
`timescale 1ns/1ps
`include "pbsp_consts.svh"
interface pbsp_if #(
  parameter int AW = `PBSP_ADDR_W,
  parameter int NL = `PBSP_LANES,
  parameter int LW = `PBSP_LANE_W
);
  logic [AW-1:0] addr;
  logic select_a_n;
  logic select_b;
  logic select_c_n;
  logic write_n;
  logic [NL-1:0] byte_lane_write_n;
  logic advance_or_load;
  logic clk_qualify_n;
  logic out_enable_n;
  logic sleep_request;
  logic burst_order;
  // data and parity lanes, three signals per end
  logic [NL*LW-1:0] dq_ctl_o;
  logic [NL*LW-1:0] dq_mem_o;
  logic [NL-1:0] parity_lanes_ctl_o;
  logic [NL-1:0] parity_lanes_mem_o;
  logic dq_ctl_oe_n;
  logic dq_mem_oe_n;
  modport mem (
    input addr, select_a_n, select_b, select_c_n, write_n, byte_lane_write_n,
    input advance_or_load, clk_qualify_n, out_enable_n, sleep_request, burst_order,
    input dq_ctl_o, parity_lanes_ctl_o,
    output dq_mem_o, parity_lanes_mem_o, dq_mem_oe_n
  );
  modport ctl (
    output addr, select_a_n, select_b, select_c_n, write_n, byte_lane_write_n,
    output advance_or_load, clk_qualify_n, out_enable_n, sleep_request, burst_order,
    output dq_ctl_o, parity_lanes_ctl_o, dq_ctl_oe_n,
    input dq_mem_o, parity_lanes_mem_o
  );
endinterface

//--- pbsp_mem.sv
// Operation
// - parity lane written with its byte select
// - strap high interleaved, low linear order
// - controller holds burst strap steady
// - sleep request holds contents, blocks access
// - sleep input low for normal work
// - all synchronous inputs registered on edge
// - qualifier high freezes every state; qualifier, sleep, output enable and asleep_o registers still update
// - read data leaves through output register
// - load edge: selects active, load low
// - write strobe low at load means write
// - unselected byte lanes stay unaltered
// - writes self-timed, no external pulse
// - reads, writes, deselects all pipelined
// - controller loads fresh address after deselect
// - read data follows edge after load
// - advance steps two-bit counter, keeps type
// - write data taken second edge after address
// - outputs off in write, deselect, first cycle
`timescale 1ns/1ps
`include "pbsp_consts.svh"
module pbsp_mem #(
  parameter int AW = `PBSP_ADDR_W,
  parameter int NL = `PBSP_LANES,
  parameter int LW = `PBSP_LANE_W
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  pbsp_if.mem bus,
  output logic asleep_o
);
  import pbsp_pkg::*;

  localparam int DW = NL * (LW + 1);

  initial begin
    if (AW < 2 || NL < 1 || LW < 1) $error("pbsp_mem: bad geometry");
  end

  // --------------------------------------------------------------------------
  // input registers
  // --------------------------------------------------------------------------
  logic [AW-1:0] addr_r;
  logic sel_ok_r, load_r, write_r, oe_n_r, order_r, sleep_r;
  logic [NL-1:0] bw_n_r;
  logic [NL*LW-1:0] din_r;
  logic [NL-1:0] pin_r;
  logic qual_r;

  // everything captured on the edge; the qualifier itself is always sampled
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      qual_r <= 1'b0;
      addr_r <= '0;
      sel_ok_r <= 1'b0;
      load_r <= 1'b0;
      write_r <= 1'b0;
      bw_n_r <= '1;
      din_r <= '0;
      pin_r <= '0;
      oe_n_r <= 1'b1;
      order_r <= `PBSP_ORDER_INTERLEAVED;
      sleep_r <= 1'b0;
    end else begin
      qual_r <= !bus.clk_qualify_n;
      sleep_r <= bus.sleep_request;
      oe_n_r <= bus.out_enable_n;
      if (!bus.clk_qualify_n) begin
        addr_r <= bus.addr;
        sel_ok_r <= !bus.select_a_n && bus.select_b && !bus.select_c_n;
        load_r <= !bus.advance_or_load;
        write_r <= !bus.write_n;
        bw_n_r <= bus.byte_lane_write_n;
        din_r <= bus.dq_ctl_o;
        pin_r <= bus.parity_lanes_ctl_o;
        order_r <= bus.burst_order;
      end
    end
  end

  // --------------------------------------------------------------------------
  // command decode and burst counter
  // --------------------------------------------------------------------------
  localparam int PW = NL * LW;

  pbsp_op_t op_r;
  pbsp_op_t op_d1_r;
  pbsp_op_t cmd_op;
  logic [AW-1:0] base_r;
  logic [AW-1:0] start_addr;
  logic [AW-1:0] cmd_addr;
  logic [AW-1:0] acc_addr_r;
  logic [AW-1:0] addr_d1_r;
  logic [NL-1:0] acc_bw_n_r;
  logic [NL-1:0] bw_d1_n_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] low_bits;
  logic act;

  // an edge acts on the registered command only if that command was qualified
  assign act = qual_r && !sleep_r;

  // a load restarts the count, an advance steps it whatever the selects say
  assign cnt_nxt = load_r ? 2'h0 : cnt_r + 2'h1;
  assign start_addr = load_r ? addr_r : base_r;

  // the strap is sampled every qualified edge, so a stray toggle upsets only bursts
  // interleave xors the count into the low bits, linear adds it with wrap
  assign low_bits = (order_r == `PBSP_ORDER_INTERLEAVED) ? (start_addr[1:0] ^ cnt_nxt)
                                                         : (start_addr[1:0] + cnt_nxt);
  assign cmd_addr = {start_addr[AW-1:2], low_bits};

  // the access type is fixed at the load and carried through the burst
  always_comb begin
    if (!load_r) begin
      cmd_op = op_r;
    end else if (!sel_ok_r) begin
      cmd_op = PBSP_OP_IDLE;
    end else if (write_r) begin
      cmd_op = PBSP_OP_WRITE;
    end else begin
      cmd_op = PBSP_OP_READ;
    end
  end

  // --------------------------------------------------------------------------
  // command stage
  // --------------------------------------------------------------------------
  // byte selects ride with each beat's command, as every burst beat needs its own
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      op_r <= PBSP_OP_IDLE;
      base_r <= '0;
      cnt_r <= 2'h0;
      acc_addr_r <= '0;
      acc_bw_n_r <= '1;
    end else if (act) begin
      op_r <= cmd_op;
      base_r <= start_addr;
      cnt_r <= cnt_nxt;
      acc_addr_r <= cmd_addr;
      acc_bw_n_r <= bw_n_r;
    end else if (qual_r) begin
      op_r <= PBSP_OP_IDLE; // accesses pending at sleep are dropped
    end
  end

  // --------------------------------------------------------------------------
  // data stage: write data arrives on the pins here
  // --------------------------------------------------------------------------
  // reads and writes keep one spacing, so the bus never needs a turnaround
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      op_d1_r <= PBSP_OP_IDLE;
      addr_d1_r <= '0;
      bw_d1_n_r <= '1;
    end else if (qual_r) begin
      op_d1_r <= sleep_r ? PBSP_OP_IDLE : op_r;
      addr_d1_r <= acc_addr_r;
      bw_d1_n_r <= acc_bw_n_r;
    end
  end

  // --------------------------------------------------------------------------
  // storage array
  // --------------------------------------------------------------------------
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // byte selects of the write steer both data and parity lanes
  always_ff @(posedge core_clk_i) begin
    if (act && op_d1_r == PBSP_OP_WRITE) begin
      for (int l = 0; l < NL; l++) begin
        if (!bw_d1_n_r[l]) begin
          mem_r[addr_d1_r][l*LW +: LW] <= din_r[l*LW +: LW];
          mem_r[addr_d1_r][PW + l] <= pin_r[l];
        end
      end
    end
  end

  // writes not yet in the array are forwarded, the newest one last
  logic [DW-1:0] rd_word;
  always_comb begin
    rd_word = mem_r[cmd_addr];
    // write landing at this edge: its data sits in the input register
    if (op_d1_r == PBSP_OP_WRITE && addr_d1_r == cmd_addr) begin
      for (int l = 0; l < NL; l++) begin
        if (!bw_d1_n_r[l]) begin
          rd_word[l*LW +: LW] = din_r[l*LW +: LW];
          rd_word[PW + l] = pin_r[l];
        end
      end
    end
    // the write just before this read has its data on the pins now
    if (op_r == PBSP_OP_WRITE && acc_addr_r == cmd_addr) begin
      for (int l = 0; l < NL; l++) begin
        if (!acc_bw_n_r[l]) begin
          rd_word[l*LW +: LW] = bus.dq_ctl_o[l*LW +: LW];
          rd_word[PW + l] = bus.parity_lanes_ctl_o[l];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // output registers
  // --------------------------------------------------------------------------
  logic [PW-1:0] dout_r;
  logic [NL-1:0] pout_r;
  logic drive_n_r;

  // read data registered one edge after the load; drivers off for anything else
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      dout_r <= '0;
      pout_r <= '0;
      drive_n_r <= 1'b1;
    end else if (qual_r) begin
      dout_r <= rd_word[PW-1:0];
      pout_r <= rd_word[DW-1:PW];
      drive_n_r <= !(act && cmd_op == PBSP_OP_READ);
    end
  end

  assign bus.dq_mem_o = dout_r;
  assign bus.parity_lanes_mem_o = pout_r;
  // sleep masks the drivers at once, even while the clock is held off
  assign bus.dq_mem_oe_n = drive_n_r | oe_n_r | sleep_r;

  // status of the sleep request as seen by the array
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) asleep_o <= 1'b0;
    else asleep_o <= sleep_r;
  end
endmodule // pbsp_mem

//--- pbsp_ctl.sv
`timescale 1ns/1ps
`include "pbsp_consts.svh"
module pbsp_ctl #(
  parameter int AW = `PBSP_ADDR_W,
  parameter int NL = `PBSP_LANES,
  parameter int LW = `PBSP_LANE_W
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [NL*(LW+1)-1:0] req_wdata_i,
  input wire logic [NL-1:0] req_bw_n_i,
  input wire logic hold_i,
  input wire logic sleep_i,
  input wire logic order_i,
  output logic busy_o,
  output logic rvalid_o,
  output logic [NL*(LW+1)-1:0] rdata_o,
  pbsp_if.ctl bus
);
  import pbsp_pkg::*;

  initial begin
    if (AW < 2 || NL < 1 || LW < 1) $error("pbsp_ctl: bad geometry");
  end

  // --------------------------------------------------------------------------
  // command drive: one load per request, deselect otherwise
  // --------------------------------------------------------------------------
  logic [2:0] wr_pipe_r, rd_pipe_r;
  logic [NL*(LW+1)-1:0] wd0_r, wd1_r, wd2_r;
  logic oe_n_r, sel_r, wr_r, hold_r, sleep_r, order_r;
  logic [AW-1:0] addr_r;
  logic [NL-1:0] bw_r;

  // always loads with advance low, so restart after deselect is a fresh load
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sel_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= '0;
      bw_r <= '1;
      wd0_r <= '0;
      hold_r <= 1'b0;
      sleep_r <= 1'b0;
      order_r <= `PBSP_ORDER_INTERLEAVED;
    end else begin
      hold_r <= hold_i;
      sleep_r <= sleep_i;
      order_r <= order_i;
      if (!hold_i) begin
        sel_r <= req_i && !sleep_i;
        wr_r <= req_write_i;
        addr_r <= req_addr_i;
        bw_r <= req_bw_n_i;
        wd0_r <= req_wdata_i; // taken with its request, not with the clock hold
      end
    end
  end

  // write data two edges after its address, read data two edges later too
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_pipe_r <= '0;
      rd_pipe_r <= '0;
      wd1_r <= '0;
      wd2_r <= '0;
      oe_n_r <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
    end else if (!hold_r) begin
      wr_pipe_r <= {wr_pipe_r[1:0], sel_r && wr_r};
      rd_pipe_r <= {rd_pipe_r[1:0], sel_r && !wr_r};
      wd1_r <= wd0_r;
      wd2_r <= wd1_r;
      oe_n_r <= !(sel_r && !wr_r); // memory registers the enable one edge later
      rvalid_o <= rd_pipe_r[1];
      rdata_o <= {bus.parity_lanes_mem_o, bus.dq_mem_o};
    end else begin
      rvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) busy_o <= 1'b0;
    else busy_o <= |wr_pipe_r | |rd_pipe_r;
  end

  assign bus.addr = addr_r;
  assign bus.select_a_n = !sel_r;
  assign bus.select_b = sel_r;
  assign bus.select_c_n = !sel_r;
  assign bus.write_n = !wr_r;
  assign bus.byte_lane_write_n = bw_r;
  assign bus.advance_or_load = 1'b0;
  assign bus.clk_qualify_n = hold_r;
  assign bus.out_enable_n = oe_n_r;
  assign bus.sleep_request = sleep_r;
  assign bus.burst_order = order_r;
  assign bus.dq_ctl_o = wd2_r[NL*LW-1:0];
  assign bus.parity_lanes_ctl_o = wd2_r[NL*(LW+1)-1:NL*LW];
  assign bus.dq_ctl_oe_n = !wr_pipe_r[1];
endmodule // pbsp_ctl

//--- pbsp_properties.sv
`timescale 1ns/1ps
module pbsp_properties (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic select_c_n,
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic clk_qualify_n,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic [31:0] dq_mem_o,
  input wire logic dq_ctl_oe_n,
  input wire logic dq_mem_oe_n
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // --------------------------------------------------------------------------
  // load edges seen on the pins
  // --------------------------------------------------------------------------
  wire ld = !clk_qualify_n && !advance_or_load && !sleep_request;
  wire sel = !select_a_n && select_b && !select_c_n;
  sequence s_rd; ld && sel && write_n; endsequence
  sequence s_wr; ld && sel && !write_n; endsequence
  sequence s_ds; ld && !sel; endsequence
  // the data phase of every access is seen two edges after its load edge
  property p_no_clash; !(!dq_ctl_oe_n && !dq_mem_oe_n); endproperty
  property p_read; s_rd |-> ##2 !dq_mem_oe_n; endproperty
  property p_write; s_wr ##1 !clk_qualify_n |-> ##1 (!dq_ctl_oe_n && dq_mem_oe_n); endproperty
  property p_desel; s_ds |-> ##2 dq_mem_oe_n; endproperty
  property p_oe; out_enable_n [*2] |-> dq_mem_oe_n; endproperty
  property p_freeze; clk_qualify_n [*2] |=> $stable(dq_mem_o); endproperty
  property p_sleep; sleep_request [*3] |-> dq_mem_oe_n; endproperty
  property p_burst;
    s_rd ##1 (advance_or_load && !clk_qualify_n) |-> ##[1:3] (out_enable_n || !dq_mem_oe_n);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  a_read: assert property (p_read) else $error("read data not driven");
  a_write: assert property (p_write) else $error("write data phase wrong");
  a_desel: assert property (p_desel) else $error("deselect left outputs on");
  a_oe: assert property (p_oe) else $error("output enable ignored");
  a_freeze: assert property (p_freeze) else $error("frozen clock moved data");
  a_sleep: assert property (p_sleep) else $error("sleeping memory drives");
  a_burst: assert property (p_burst) else $error("burst beat not driven");
endmodule // pbsp_properties

//--- pipelined_burst_sram_port_tb_top.sv
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb_top;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_i = 1'b0, req_write_i = 1'b0, hold_i = 1'b0, sleep_i = 1'b0, order_i = 1'b1;
  logic [7:0] req_addr_i = 8'h00;
  logic [35:0] req_wdata_i = 36'h0;
  logic [3:0] req_bw_n_i = 4'hf;
  logic busy_o, rvalid_o, asleep_o;
  logic [35:0] rdata_o;
  logic [35:0] model [0:255];
  logic [35:0] expq [$];
  logic [7:0] addrs [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  int n_fail = 0;
  int total_checks = 0;
  pbsp_if u_pbsp_if ();
  pbsp_mem u_pbsp_mem (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus(u_pbsp_if),
    .asleep_o(asleep_o));
  pbsp_ctl u_pbsp_ctl (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_bw_n_i(req_bw_n_i), .hold_i(hold_i), .sleep_i(sleep_i), .order_i(order_i),
    .busy_o(busy_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .bus(u_pbsp_if));
  pbsp_properties u_props (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .select_a_n(u_pbsp_if.select_a_n), .select_b(u_pbsp_if.select_b),
    .select_c_n(u_pbsp_if.select_c_n), .write_n(u_pbsp_if.write_n),
    .advance_or_load(u_pbsp_if.advance_or_load), .clk_qualify_n(u_pbsp_if.clk_qualify_n),
    .out_enable_n(u_pbsp_if.out_enable_n), .sleep_request(u_pbsp_if.sleep_request),
    .dq_mem_o(u_pbsp_if.dq_mem_o), .dq_ctl_oe_n(u_pbsp_if.dq_ctl_oe_n),
    .dq_mem_oe_n(u_pbsp_if.dq_mem_oe_n));
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  initial forever #2 core_clk_i = ~core_clk_i;
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request per edge; the model is updated in request order, as the port is
  task automatic put(input logic w, input logic [7:0] a, input logic [35:0] d,
    input logic [3:0] bw);
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_bw_n_i <= bw;
    if (w) begin
      for (int l = 0; l < 4; l++) if (!bw[l]) begin
        model[a][l*8 +: 8] = d[l*8 +: 8];
        model[a][32+l] = d[32+l];
      end
    end else expq.push_back(model[a]);
  endtask
  task automatic drain;
    @(posedge core_clk_i);
    req_i <= 1'b0;
    for (int i = 0; i < 80 && (expq.size() > 0 || busy_o !== 1'b0); i++) @(posedge core_clk_i);
    check(36'(expq.size()), 36'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // read data arrives in request order
  always @(posedge core_clk_i) if (rvalid_o === 1'b1) check(rdata_o, expq.pop_front());
  initial begin
    #40000;
    n_fail++;
    test_done;
  end
  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int o = 0; o < 2; o++) begin
      order_i <= o[0]; // changed only while idle
      foreach (addrs[i]) put(1'b1, addrs[i], {addrs[i][3:0], {4{addrs[i]}}} ^ o, 4'h0);
      foreach (addrs[i]) put(1'b0, addrs[i], 36'h0, 4'hf);
      drain();
    end
    // partial writes mixed back to back with reads
    put(1'b1, 8'h01, 36'hf_0123_4567, 4'b1010);
    put(1'b0, 8'h01, 36'h0, 4'hf);
    put(1'b1, 8'h02, 36'h5_89ab_cdef, 4'b0110);
    put(1'b0, 8'h02, 36'h0, 4'hf);
    put(1'b0, 8'hff, 36'h0, 4'hf);
    drain();
    // request waits while the clock is held off
    hold_i <= 1'b1;
    put(1'b0, 8'h00, 36'h0, 4'hf);
    repeat (6) @(posedge core_clk_i);
    check(36'(expq.size()), 36'h1);
    hold_i <= 1'b0;
    drain();
    sleep_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check({35'h0, asleep_o}, 36'h1);
    sleep_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    check({35'h0, asleep_o}, 36'h0);
    foreach (addrs[i]) put(1'b0, addrs[i], 36'h0, 4'hf);
    drain();
    test_done;
  end
endmodule // pipelined_burst_sram_port_tb_top
